//--- fss_status_sleep_map.svh
`ifndef FSS_STATUS_SLEEP_MAP_SVH
`define FSS_STATUS_SLEEP_MAP_SVH

// Core clock rate
`define FSS_CLK_MHZ 200

// Opcodes seen on the serial link
`define FSS_OP_STATUS 8'hd7
`define FSS_OP_DEEP 8'hb9
`define FSS_OP_RESUME 8'hab
`define FSS_OP_ULTRA 8'h79

// Bit positions inside each status byte
`define FSS_B_READY 7
`define FSS_B1_CMP 6
`define FSS_B1_CAP_HI 5
`define FSS_B1_CAP_LO 2
`define FSS_B1_GUARD 1
`define FSS_B1_BINPAGE 0
`define FSS_B2_SPARE_HI 6
`define FSS_B2_FAIL 5
`define FSS_B2_SPARE_LO 4
`define FSS_B2_LOCKDOWN 3
`define FSS_B2_SUSP_TWO 2
`define FSS_B2_SUSP_ONE 1
`define FSS_B2_ERASE_HELD 0

// Timing figures in ns
`define FSS_DPD_ENTRY_NS 3000
`define FSS_DPD_EXIT_NS 35000
`define FSS_UDPD_ENTRY_NS 3000
`define FSS_UDPD_EXIT_NS 70000
`define FSS_SEL_PULSE_MIN_NS 20

// Widths and reset values
`define FSS_TMR_W 20
`define FSS_BITS_PER_BYTE 3'h7
`define FSS_LAST_STATUS_BIT 4'hf
`define FSS_CAPACITY_DEFAULT 4'h5

`endif

//--- fss_pkg.sv
`include "fss_status_sleep_map.svh"

package fss_pkg;

  // Power modes of the device
  typedef enum logic [2:0] {
    FSS_STANDBY,
    FSS_ENTER_DEEP,
    FSS_DEEP,
    FSS_EXIT_DEEP,
    FSS_ENTER_ULTRA,
    FSS_ULTRA,
    FSS_WAKE
  } fss_mode_t;

  // Meaning of a frame if it ended now
  typedef enum logic [1:0] {
    FSS_VD_NONE,
    FSS_VD_DEEP,
    FSS_VD_RESUME,
    FSS_VD_ULTRA
  } fss_verdict_t;

  // Serial clock side state
  typedef struct packed {
    logic slp_s1;
    logic slp_s2;
    logic [15:0] st_s1;
    logic [15:0] st_s2;
    logic [6:0] sh;
    logic [2:0] bit_cnt;
    logic got_byte;
    logic [7:0] op;
    logic reading;
    logic [3:0] idx;
    logic so;
    logic so_oe;
    fss_verdict_t vd;
  } fss_link_t;

  // Core clock side state
  typedef struct packed {
    logic cs_s1;
    logic cs_s2;
    logic cs_s3;
    fss_verdict_t vd_s1;
    fss_verdict_t vd_s2;
    fss_verdict_t vd_last;
    logic [`FSS_TMR_W-1:0] low_cnt;
    logic [`FSS_TMR_W-1:0] tmr;
    fss_mode_t mode;
    logic ign;
    logic busy;
    logic fail;
    logic cmp;
    logic lockdown;
    logic guard;
    logic binpg;
    logic susp_one;
    logic susp_two;
    logic erase_held;
    logic [15:0] stat;
    logic sleep;
    logic standby;
    logic deep;
    logic ultra;
    logic cmd_en;
    logic buf_lost;
  } fss_core_t;

endpackage

//--- fss_status_sleep.sv
// Notes on behaviour
// R1: Status bit 7 reads 0 while busy, 1 when ready.
// R2: Second byte bits 6 and 4 always read 0.
// R3: Fail flag refreshed after each erase/program; 1 on failure, 0 on success.
// R4: An aborted erase/program leaves the fail flag clear.
// R5: Lockdown bit reads 1 while lockdown command is still enabled.
// R6: Buffer two suspend bit shown; writes to buffer two blocked meanwhile.
// R7: Buffer one suspend bit shown; writes to buffer one blocked meanwhile.
// R8: Erase held bit reads 1 while an erase is suspended.
// R9: Compare bit holds result of latest page to buffer compare.
// R10: Capacity field returns a fixed four-bit legacy code.
// R11: Guard bit shows sector protection, whichever method enabled it.
// R12: Binary page bit shows 512 or 528 byte page configuration.
// R13: Host polls status repeatedly until ready goes from 0 to 1.
// R14: Standby when deselected and idle, and after power-up.
// R15: Deep sleep ignores all commands except resume.
// R16: Opcode B9h then deselect enters deep sleep; trailing bytes ignored.
// R17: Incomplete or misaligned sleep entry frame aborts, stays in standby.
// R18: Sleep entry opcodes ignored while a self-timed operation runs.
// R19: Opcode ABh then deselect returns to standby within exit time.
// R20: Incomplete or misaligned resume frame leaves device in deep sleep.
// R21: Opcode 79h enters ultra sleep; all commands ignored; buffers lost.
// R22: Select pulse of minimum length leaves ultra sleep within exit time.
// R23: Frames started before ultra wake completes are ignored entirely.
// R24: First status byte carries ready, compare, capacity, guard, page bits.
// R25: After D7h status bytes one and two repeat while selected.
// R26: Serial output stays undriven during deep or ultra sleep.
module fss_status_sleep #(
  // Arbitrary value, not a real part code
  parameter logic [3:0] CAPACITY_CODE = `FSS_CAPACITY_DEFAULT,
  parameter int unsigned DPD_ENTRY_CYC =
    (`FSS_DPD_ENTRY_NS * `FSS_CLK_MHZ / 1000 < 1) ? 1 : `FSS_DPD_ENTRY_NS * `FSS_CLK_MHZ / 1000,
  parameter int unsigned DPD_EXIT_CYC =
    (`FSS_DPD_EXIT_NS * `FSS_CLK_MHZ / 1000 < 1) ? 1 : `FSS_DPD_EXIT_NS * `FSS_CLK_MHZ / 1000,
  parameter int unsigned UDPD_ENTRY_CYC =
    (`FSS_UDPD_ENTRY_NS * `FSS_CLK_MHZ / 1000 < 1) ? 1 : `FSS_UDPD_ENTRY_NS * `FSS_CLK_MHZ / 1000,
  parameter int unsigned UDPD_EXIT_CYC =
    (`FSS_UDPD_EXIT_NS * `FSS_CLK_MHZ / 1000 < 1) ? 1 : `FSS_UDPD_EXIT_NS * `FSS_CLK_MHZ / 1000,
  parameter int unsigned SEL_PULSE_CYC =
    ((`FSS_SEL_PULSE_MIN_NS * `FSS_CLK_MHZ + 999) / 1000 < 1) ? 1 :
    (`FSS_SEL_PULSE_MIN_NS * `FSS_CLK_MHZ + 999) / 1000
) (
  // Core clock and reset
  input wire logic mclk_in,
  input wire logic rst_in,
  // Serial link
  input wire logic sck_in,
  input wire logic cs_n_in,
  input wire logic si_in,
  output logic so_out,
  output logic so_oe_out,
  // Status sources from the rest of the device
  input wire logic busy_in,
  input wire logic op_end_in,
  input wire logic op_err_in,
  input wire logic op_abort_in,
  input wire logic cmp_done_in,
  input wire logic cmp_diff_in,
  input wire logic lockdown_en_in,
  input wire logic guard_en_in,
  input wire logic binary_page_in,
  input wire logic susp_buf_one_in,
  input wire logic susp_buf_two_in,
  input wire logic erase_held_in,
  // Power state and gating outputs
  output logic standby_out,
  output logic deep_sleep_out,
  output logic ultra_sleep_out,
  output logic cmd_en_out,
  output logic buf_lost_out,
  output logic buf_one_frozen_out,
  output logic buf_two_frozen_out
);

  localparam logic [`FSS_TMR_W-1:0] TMR_ZERO = '0;
  localparam logic [`FSS_TMR_W-1:0] TMR_MAX = '1;

  fss_pkg::fss_link_t lq;
  fss_pkg::fss_link_t ld;
  fss_pkg::fss_core_t q;
  fss_pkg::fss_core_t d;
  logic [7:0] op_now;

  ////////////////////////////////////////////////////////////////////////////
  // Link side, clocked by the serial clock

  // Opcode as it stands after this edge
  assign op_now = {lq.sh, si_in};

  // Shift, decode and status streaming
  always_comb begin
    ld = lq;
    ld.st_s1 = q.stat;
    ld.st_s2 = lq.st_s1;
    ld.slp_s1 = q.sleep;
    ld.slp_s2 = lq.slp_s1;
    ld.sh = op_now[6:0];
    ld.bit_cnt = lq.bit_cnt + 3'h1;
    // R16 first byte only
    if (lq.bit_cnt == `FSS_BITS_PER_BYTE && !lq.got_byte) begin
      ld.got_byte = 1'b1;
      ld.op = op_now;
      // R25 status read start
      // R15 sleep blocks it
      // R26 output stays off
      if (op_now == `FSS_OP_STATUS && !lq.slp_s2) begin
        ld.reading = 1'b1;
        ld.so_oe = 1'b1;
        ld.so = lq.st_s2[`FSS_LAST_STATUS_BIT];
        ld.idx = 4'h1;
      end
    end
    // R25 repeat both bytes
    if (lq.reading) begin
      ld.so = lq.st_s2[`FSS_LAST_STATUS_BIT - lq.idx];
      ld.idx = lq.idx + 4'h1;
    end
    // R17 aligned whole bytes
    // R20 aligned resume only
    ld.vd = fss_pkg::FSS_VD_NONE;
    if (ld.got_byte && ld.bit_cnt == 3'h0) begin
      unique case (ld.op)
        `FSS_OP_DEEP: ld.vd = fss_pkg::FSS_VD_DEEP;
        `FSS_OP_RESUME: ld.vd = fss_pkg::FSS_VD_RESUME;
        `FSS_OP_ULTRA: ld.vd = fss_pkg::FSS_VD_ULTRA;
        default: ld.vd = fss_pkg::FSS_VD_NONE;
      endcase
    end
  end

  // Deselect clears the frame and releases the output
  always_ff @(posedge sck_in or posedge cs_n_in) begin
    if (cs_n_in) begin
      lq <= '0;
    end else begin
      lq <= ld;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Core side, clocked by the core clock

  // Flags, power modes and output drive
  always_comb begin
    d = q;
    d.cs_s1 = cs_n_in;
    d.cs_s2 = q.cs_s1;
    d.cs_s3 = q.cs_s2;
    d.vd_s1 = lq.vd;
    d.vd_s2 = q.vd_s1;
    // Keep the verdict seen before deselect
    if (!q.cs_s2) begin
      d.vd_last = q.vd_s2;
    end
    d.low_cnt = q.cs_s2 ? TMR_ZERO : ((q.low_cnt == TMR_MAX) ? q.low_cnt : q.low_cnt + 1'b1);
    d.tmr = (q.tmr != TMR_ZERO) ? q.tmr - 1'b1 : TMR_ZERO;
    d.buf_lost = 1'b0;

    // R1 busy sampled
    d.busy = busy_in;
    // R3 refresh fail flag
    // R4 abort keeps clear
    if (op_end_in) begin
      d.fail = op_err_in & ~op_abort_in;
    end
    // R9 latest compare
    if (cmp_done_in) begin
      d.cmp = cmp_diff_in;
    end
    // R5 lockdown state
    d.lockdown = lockdown_en_in;
    // R11 protection state
    d.guard = guard_en_in;
    // R12 page size
    d.binpg = binary_page_in;
    // R6 R7 R8 suspend state
    d.susp_one = susp_buf_one_in;
    d.susp_two = susp_buf_two_in;
    d.erase_held = erase_held_in;

    // R23 frame begun out of standby
    if (!q.cs_s2 && q.cs_s3) begin
      d.ign = (q.mode != fss_pkg::FSS_STANDBY);
    end

    unique case (q.mode)
      fss_pkg::FSS_STANDBY: begin
        // R18 busy blocks entry
        if (q.cs_s2 && !q.cs_s3 && !q.ign && !q.busy) begin
          // R16 deep sleep entry
          if (q.vd_last == fss_pkg::FSS_VD_DEEP) begin
            d.mode = fss_pkg::FSS_ENTER_DEEP;
            d.tmr = `FSS_TMR_W'(DPD_ENTRY_CYC - 1);
          end
          // R21 ultra sleep entry
          if (q.vd_last == fss_pkg::FSS_VD_ULTRA) begin
            d.mode = fss_pkg::FSS_ENTER_ULTRA;
            d.tmr = `FSS_TMR_W'(UDPD_ENTRY_CYC - 1);
          end
        end
      end
      fss_pkg::FSS_ENTER_DEEP: begin
        if (q.tmr == TMR_ZERO) begin
          d.mode = fss_pkg::FSS_DEEP;
        end
      end
      fss_pkg::FSS_DEEP: begin
        // R19 resume only
        if (q.cs_s2 && !q.cs_s3 && q.vd_last == fss_pkg::FSS_VD_RESUME) begin
          d.mode = fss_pkg::FSS_EXIT_DEEP;
          d.tmr = `FSS_TMR_W'(DPD_EXIT_CYC - 1);
        end
      end
      fss_pkg::FSS_EXIT_DEEP: begin
        if (q.tmr == TMR_ZERO) begin
          d.mode = fss_pkg::FSS_STANDBY;
        end
      end
      fss_pkg::FSS_ENTER_ULTRA: begin
        if (q.tmr == TMR_ZERO) begin
          d.mode = fss_pkg::FSS_ULTRA;
          // R21 buffers lost
          d.buf_lost = 1'b1;
        end
      end
      fss_pkg::FSS_ULTRA: begin
        // R22 long enough select pulse
        if (q.cs_s2 && !q.cs_s3 && q.low_cnt >= `FSS_TMR_W'(SEL_PULSE_CYC)) begin
          d.mode = fss_pkg::FSS_WAKE;
          d.tmr = `FSS_TMR_W'(UDPD_EXIT_CYC - 1);
        end
      end
      fss_pkg::FSS_WAKE: begin
        if (q.tmr == TMR_ZERO) begin
          d.mode = fss_pkg::FSS_STANDBY;
        end
      end
      default: begin
        d.mode = fss_pkg::FSS_STANDBY;
      end
    endcase

    // R24 first status byte
    d.stat[15:8] = 8'h00;
    d.stat[8 + `FSS_B_READY] = ~q.busy;
    d.stat[8 + `FSS_B1_CMP] = q.cmp;
    // R10 fixed capacity code
    d.stat[8 + `FSS_B1_CAP_HI:8 + `FSS_B1_CAP_LO] = CAPACITY_CODE;
    d.stat[8 + `FSS_B1_GUARD] = q.guard;
    d.stat[8 + `FSS_B1_BINPAGE] = q.binpg;
    // R2 spare bits zero
    d.stat[7:0] = 8'h00;
    d.stat[`FSS_B_READY] = ~q.busy;
    d.stat[`FSS_B2_SPARE_HI] = 1'b0;
    d.stat[`FSS_B2_FAIL] = q.fail;
    d.stat[`FSS_B2_SPARE_LO] = 1'b0;
    d.stat[`FSS_B2_LOCKDOWN] = q.lockdown;
    d.stat[`FSS_B2_SUSP_TWO] = q.susp_two;
    d.stat[`FSS_B2_SUSP_ONE] = q.susp_one;
    d.stat[`FSS_B2_ERASE_HELD] = q.erase_held;

    // R15 R26 link muted out of standby
    d.sleep = (d.mode != fss_pkg::FSS_STANDBY) || (!q.cs_s2 && d.ign);
    // R14 standby when idle and deselected
    d.standby = (d.mode == fss_pkg::FSS_STANDBY) && q.cs_s2 && !q.busy;
    d.deep = (d.mode == fss_pkg::FSS_DEEP);
    d.ultra = (d.mode == fss_pkg::FSS_ULTRA);
    // R15 R23 other commands gated
    d.cmd_en = !d.sleep;
  end

  // Core state register
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      q <= '0;
      q.cs_s1 <= 1'b1;
      q.cs_s2 <= 1'b1;
      q.cs_s3 <= 1'b1;
      q.lockdown <= 1'b1;
      q.stat <= '0;
      q.cmd_en <= 1'b1;
    end else begin
      q <= d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign so_out = lq.so;
  assign so_oe_out = lq.so_oe;
  assign standby_out = q.standby;
  assign deep_sleep_out = q.deep;
  assign ultra_sleep_out = q.ultra;
  assign cmd_en_out = q.cmd_en;
  assign buf_lost_out = q.buf_lost;
  // R6 buffer two write block
  assign buf_two_frozen_out = q.susp_two;
  // R7 buffer one write block
  assign buf_one_frozen_out = q.susp_one;

endmodule

//--- fss_status_sleep_props.sv
module fss_status_sleep_props (
  // Clock and reset
  input wire logic mclk_in,
  input wire logic rst_in,
  // Watched inputs
  input wire logic busy_in,
  input wire logic susp_buf_one_in,
  input wire logic susp_buf_two_in,
  // Watched outputs
  input wire logic so_oe_out,
  input wire logic standby_out,
  input wire logic deep_sleep_out,
  input wire logic ultra_sleep_out,
  input wire logic cmd_en_out,
  input wire logic buf_lost_out,
  input wire logic buf_one_frozen_out,
  input wire logic buf_two_frozen_out
);
  default clocking cb @(posedge mclk_in);
  endclocking
  default disable iff (rst_in);

  AST_QUIET_ASLEEP: assert property (
    (deep_sleep_out || ultra_sleep_out) |-> !so_oe_out) else $error("so driven asleep");
  AST_ONE_MODE: assert property (
    $onehot0({standby_out, deep_sleep_out, ultra_sleep_out})) else $error("two modes");
  AST_BUSY_NO_STANDBY: assert property (
    busy_in [*3] |-> !standby_out) else $error("standby while busy");
  AST_FREEZE_ONE: assert property (
    susp_buf_one_in [*3] |-> buf_one_frozen_out) else $error("buffer one open");
  AST_FREEZE_TWO: assert property (
    susp_buf_two_in [*3] |-> buf_two_frozen_out) else $error("buffer two open");
  AST_LOST_PULSE: assert property (
    buf_lost_out |=> !buf_lost_out && ultra_sleep_out) else $error("bad lost pulse");
  AST_CMD_OFF: assert property (
    (deep_sleep_out || ultra_sleep_out) |-> !cmd_en_out) else $error("cmds open asleep");
  AST_DEEP_EXIT: assert property (
    $fell(deep_sleep_out) |-> ##[1:12] standby_out) else $error("slow deep exit");
endmodule

bind fss_status_sleep fss_status_sleep_props u_props (
  .mclk_in(mclk_in), .rst_in(rst_in), .busy_in(busy_in),
  .susp_buf_one_in(susp_buf_one_in), .susp_buf_two_in(susp_buf_two_in),
  .so_oe_out(so_oe_out), .standby_out(standby_out), .deep_sleep_out(deep_sleep_out),
  .ultra_sleep_out(ultra_sleep_out), .cmd_en_out(cmd_en_out), .buf_lost_out(buf_lost_out),
  .buf_one_frozen_out(buf_one_frozen_out), .buf_two_frozen_out(buf_two_frozen_out)
);

//--- fss_host_model.sv
module fss_host_model (
  // Serial link
  output logic sck_out,
  output logic cs_n_out,
  output logic si_out,
  input wire logic so_in,
  input wire logic so_oe_in
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [15:0] rd_q;
  logic drv_q;

  // Idle link, clock parked
  initial begin
    sck_out = 1'b0;
    cs_n_out = 1'b1;
    si_out = 1'b0;
  end

  ////////////////////
  // framed opcode
  task automatic frame(input logic [7:0] op, input int nbits);
    int i;
    rd_q = 16'h0000;
    drv_q = 1'b0;
    cs_n_out = 1'b0;
    #10;
    for (i = 0; i < nbits; i++) begin
      si_out = (i < 8) ? op[7-i] : ~si_out;
      #3;
      if (i >= 8) begin
        rd_q = {rd_q[14:0], so_in};
        drv_q = drv_q | so_oe_in;
      end
      sck_out = 1'b1;
      #3;
      sck_out = 1'b0;
    end
    #12;
    cs_n_out = 1'b1;
    si_out = ~si_out;
    #30;
  endtask

  task automatic pulse(input int ns);
    cs_n_out = 1'b0;
    #(ns);
    cs_n_out = 1'b1;
    #30;
  endtask

  task automatic poll(output logic ok);
    int n;
    ok = 1'b0;
    for (n = 0; n < 40 && !ok; n++) begin
      frame(8'hd7, 24);
      ok = rd_q[15];
    end
  endtask
endmodule

//--- test_fss_status_sleep.sv
module test_fss_status_sleep;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [3:0] CAP = 4'ha; // arbitrary code
  logic mclk_in, rst_in, sck, cs_n, si, so, so_oe, busy, op_end, op_err, op_abort;
  logic cmp_done, cmp_diff, lock, guard, binpg, s1, s2, es;
  logic standby, deep, ultra, cmd_en, lost, f1, f2, lost_seen;
  logic [2:0] mode;
  int err_count = 0;
  int total_checks = 0;
  assign mode = {standby, deep, ultra};

  fss_status_sleep #(.CAPACITY_CODE(CAP), .DPD_ENTRY_CYC(5), .DPD_EXIT_CYC(5),
    .UDPD_ENTRY_CYC(5), .UDPD_EXIT_CYC(10), .SEL_PULSE_CYC(4)) u_dut (
    .mclk_in(mclk_in), .rst_in(rst_in), .sck_in(sck), .cs_n_in(cs_n), .si_in(si),
    .so_out(so), .so_oe_out(so_oe), .busy_in(busy), .op_end_in(op_end),
    .op_err_in(op_err), .op_abort_in(op_abort), .cmp_done_in(cmp_done),
    .cmp_diff_in(cmp_diff), .lockdown_en_in(lock), .guard_en_in(guard),
    .binary_page_in(binpg), .susp_buf_one_in(s1), .susp_buf_two_in(s2),
    .erase_held_in(es), .standby_out(standby), .deep_sleep_out(deep),
    .ultra_sleep_out(ultra), .cmd_en_out(cmd_en), .buf_lost_out(lost),
    .buf_one_frozen_out(f1), .buf_two_frozen_out(f2));

  fss_host_model u_host (.sck_out(sck), .cs_n_out(cs_n), .si_out(si), .so_in(so),
    .so_oe_in(so_oe));

  // Core clock
  initial begin
    mclk_in = 1'b0;
    forever #2.5 mclk_in = ~mclk_in;
  end

  // Sticky record of the lost pulse
  initial lost_seen = 1'b0;
  always @(posedge mclk_in) if (lost) lost_seen <= 1'b1;

  ////////////////////
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk_in);
    #1;
  endtask

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic complete_run;
    $display("checks=%0d errors=%0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic wait_mode(input logic [2:0] m);
    int n;
    for (n = 0; n < 60 && mode !== m; n++) cyc(1);
  endtask

  ////////////////////
  // Flag sources f = {err,abort,cmp,lock,guard,bin,s2,s1,es}
  task automatic flags(input logic [8:0] f);
    logic [15:0] exp;
    {op_err, op_abort, cmp_diff, lock, guard, binpg, s2, s1, es} = f;
    op_end = 1'b1;
    cmp_done = 1'b1;
    cyc(1);
    op_end = 1'b0;
    cmp_done = 1'b0;
    cyc(4);
    exp = {1'b1, f[6], CAP, f[4], f[3], 1'b1, 1'b0, f[8] & ~f[7], 1'b0, f[5], f[2:0]};
    u_host.frame(8'hd7, 40);
    chk(u_host.rd_q, exp);
    chk(16'({u_host.drv_q, f2, f1}), 16'({1'b1, f[2:1]}));
  endtask

  task automatic t_busy;
    logic ok;
    busy = 1'b1;
    cyc(4);
    chk(16'(standby), 16'h0);
    u_host.frame(8'hd7, 24);
    chk(16'({u_host.rd_q[15], u_host.rd_q[7]}), 16'h0);
    u_host.frame(8'hb9, 8);
    u_host.frame(8'h79, 8);
    cyc(20);
    chk(16'(mode), 16'h0);
    busy = 1'b0;
    u_host.poll(ok);
    chk(16'(ok), 16'h1);
  endtask

  task automatic t_abort;
    int k;
    for (k = 0; k < 4; k++) begin
      u_host.frame(k[0] ? 8'hb9 : 8'h79, k < 2 ? 5 : 12);
      cyc(20);
      chk(16'(mode), 16'h4);
    end
  endtask

  task automatic t_deep;
    u_host.frame(8'hb9, 16);
    wait_mode(3'h2);
    chk(16'({mode, cmd_en}), 16'h4);
    u_host.frame(8'hd7, 24);
    chk(16'(u_host.drv_q), 16'h0);
    u_host.frame(8'hab, 9);
    cyc(20);
    chk(16'(mode), 16'h2);
    u_host.frame(8'hab, 16);
    wait_mode(3'h4);
    chk(16'(mode), 16'h4);
  endtask

  task automatic t_ultra;
    u_host.frame(8'h79, 8);
    wait_mode(3'h1);
    cyc(2);
    chk(16'({mode, lost_seen}), 16'h3);
    chk(16'(cmd_en), 16'h0);
    // Status frame in ultra sleep is ignored but its select pulse wakes
    u_host.frame(8'hd7, 24);
    chk(16'(u_host.drv_q), 16'h0);
    // Frame begun during wake is ignored
    u_host.frame(8'hd7, 24);
    chk(16'(u_host.drv_q), 16'h0);
    wait_mode(3'h4);
    u_host.frame(8'hd7, 24);
    chk(16'({mode, u_host.drv_q}), 16'h9);
    // Plain select pulse with no clocks
    u_host.frame(8'h79, 8);
    wait_mode(3'h1);
    chk(16'(mode), 16'h1);
    u_host.pulse(30);
    wait_mode(3'h4);
    chk(16'(mode), 16'h4);
  endtask

  ////////////////////
  // Main sequence
  initial begin
    {busy, op_end, op_err, op_abort, cmp_done, cmp_diff} = 6'h00;
    {lock, guard, binpg, s1, s2, es} = 6'h00;
    rst_in = 1'b1;
    cyc(3);
    rst_in = 1'b0;
    cyc(4);
    chk(16'(mode), 16'h4);
    flags(9'h173);
    flags(9'h053);
    flags(9'h18c);
    t_busy;
    t_abort;
    t_deep;
    t_ultra;
    complete_run;
  end

  // Hang guard
  initial begin
    int n;
    for (n = 0; n < 20000; n++) @(posedge mclk_in);
    err_count++;
    complete_run;
  end
endmodule
